// >>> rtl/stp_consts.svh
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// Clock rate of the block
`define STP_CLK_MHZ           100
// Calibration time, longest table setting, in nanoseconds
`define STP_CAL_TIME_NS       724000
`define STP_CAL_CYCLES        ((`STP_CAL_TIME_NS * `STP_CLK_MHZ) / 1000)
// Oscillator start-up wait after wake, in cycles
`define STP_XOSC_START_CYC    64
// Output pin select code for the lock detector
`define STP_PIN_SEL_LOCK      6'h0a
// Trim status value meaning out of lock
`define STP_TRIM_UNLOCKED     6'h3f
// Power table reset value
`define STP_PWR_DEFAULT       8'hc6
// Value left in entries lost in sleep
`define STP_PWR_LOST          8'h00
// Automatic tuning policy codes
`define STP_POLICY_MANUAL     2'h0
`define STP_POLICY_ON_START   2'h1
`define STP_POLICY_ON_STOP    2'h2

`endif

// >>> rtl/stp_pkg.sv
package stp_pkg;

  // Synthesizer and power state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CAL   = 2'b01,
    ST_RUN   = 2'b10,
    ST_SLEEP = 2'b11
  } stp_state_e;

  typedef logic [7:0] stp_level_t;
  typedef logic [2:0] stp_index_t;

endpackage

// >>> rtl/stp_pwr_tab_if.sv
`timescale 1ns/10ps
// Power table access between the controller and its memory
interface stp_pwr_tab_if;
  import stp_pkg::*;
  logic       wrEn;
  stp_index_t wrIdx;
  stp_level_t wrData;
  logic       sleepClear;
  stp_index_t rdIdx;
  stp_level_t rdData;
  modport ctrl (output wrEn, wrIdx, wrData, sleepClear, rdIdx, input rdData);
  modport mem  (input wrEn, wrIdx, wrData, sleepClear, rdIdx, output rdData);
endinterface

// >>> rtl/stp_pwr_table.sv
`timescale 1ns/10ps
`include "stp_consts.svh"
// Eight-entry output power table with registered read
module stp_pwr_table
  import stp_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic   clock,
  input  wire logic   sys_rst,
  stp_pwr_tab_if.mem  tab
);

  stp_level_t entry_q [DEPTH];
  stp_level_t rdData_q;

  // Entry 0 survives sleep, the rest are dropped
  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (sys_rst) begin
        entry_q[i] <= `STP_PWR_DEFAULT;
      end else if (tab.sleepClear && i != 0) begin
        entry_q[i] <= `STP_PWR_LOST;
      end else if (tab.wrEn && tab.wrIdx == 3'(i)) begin
        entry_q[i] <= tab.wrData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdData_q <= `STP_PWR_DEFAULT;
    end else begin
      rdData_q <= entry_q[tab.rdIdx];
    end
  end

  assign tab.rdData = rdData_q;

  table_reset_a: assert property (@(posedge clock) $past(sys_rst) |-> entry_q[0] == `STP_PWR_DEFAULT)
    else $error("power table entry 0 not at default after reset");
  entry_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    tab.sleepClear && !tab.wrEn |=> entry_q[0] == $past(entry_q[0]))
    else $error("entry 0 changed on sleep entry");

endmodule

// >>> rtl/stp_synth_ctrl.sv
`timescale 1ns/10ps
`include "stp_consts.svh"
module stp_synth_ctrl
  import stp_pkg::*;
#(
  parameter int CAL_CYCLES = `STP_CAL_CYCLES,
  parameter int XOSC_CYC   = `STP_XOSC_START_CYC,
  parameter int IF_W       = 5
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       baseWordHi,
  input  wire logic [7:0]       baseWordMid,
  input  wire logic [7:0]       baseWordLo,
  input  wire logic [7:0]       carrierSlotNumber,
  input  wire logic [7:0]       spacingMantissa,
  input  wire logic [1:0]       spacingExponent,
  input  wire logic [IF_W-1:0]  intermediateTuningWord,
  input  wire logic [1:0]       autoTunePolicy,
  input  wire logic             calibrateStrobe,
  input  wire logic             powerDownStrobe,
  input  wire logic             synthOnReq,
  input  wire logic             pllLockRaw,
  input  wire logic [5:0]       trimCode,
  input  wire logic [5:0]       outputPinSelect,
  input  wire logic             chipSelectN,
  input  wire logic             serialClk,
  input  wire logic             tableWrEn,
  input  wire logic             tableBurst,
  input  wire logic [2:0]       tableWrIdx,
  input  wire logic [7:0]       tableWrData,
  input  wire logic [2:0]       rampTopIndex,
  input  wire logic             txActive,
  input  wire logic             askMode,
  input  wire logic             ookMode,
  input  wire logic             txBit,
  input  wire logic             shapeTick,
  output logic [26:0]           synthWord,
  output logic [IF_W-1:0]       ifWord,
  output logic                  synthRunning,
  output logic                  calBusy,
  output logic [5:0]            synthTrimStatus,
  output logic                  generalOutputPin,
  output logic                  coreOn,
  output logic                  serialOut,
  output logic                  earlyClkError,
  output logic [7:0]            paLevel,
  output logic                  paEnable
);

  stp_pwr_tab_if tab ();

  stp_pwr_table #(.DEPTH(8)) uTable (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tab     (tab)
  );

  // Pin-side inputs through two flops
  logic [1:0] csSync_q, lockSync_q, sclkSync_q;
  logic       sclkPrev_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      csSync_q   <= 2'b11;
      lockSync_q <= 2'b00;
      sclkSync_q <= 2'b00;
      sclkPrev_q <= 1'b0;
    end else begin
      csSync_q   <= {csSync_q[0], chipSelectN};
      lockSync_q <= {lockSync_q[0], pllLockRaw};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  wire logic csLow    = !csSync_q[1];
  wire logic locked   = lockSync_q[1];
  wire logic sclkRise = sclkSync_q[1] && !sclkPrev_q;

  // Frequency arithmetic, two fraction bits kept for the exponent of -2
  wire logic [11:0] stepWord    = 12'({1'b1, spacingMantissa}) << spacingExponent;
  wire logic [19:0] slotOffset  = 20'(carrierSlotNumber) * 20'(stepWord);
  wire logic [26:0] carrierWord = 27'({baseWordHi, baseWordMid, baseWordLo, 2'b00}) + 27'(slotOffset);

  stp_state_e state_q, state_d;
  logic [31:0] calCnt_q;
  logic [31:0] xoscCnt_q;
  logic        pdArmed_q, synthRun_q, calBusy_q;
  logic [5:0]  trim_q;
  logic [26:0] synthWord_q;
  logic [IF_W-1:0] ifWord_q;
  logic        coreOn_q, chipRdyN_q, earlyClk_q, pin_q;
  logic [5:0]  trimStat_q;

  wire logic manualPolicy = autoTunePolicy == `STP_POLICY_MANUAL;
  wire logic calDone      = state_q == ST_CAL && calCnt_q == 32'(CAL_CYCLES - 1);
  wire logic sleepGo      = pdArmed_q && !csLow;
  wire logic enterCal     = state_d == ST_CAL && state_q != ST_CAL;
  wire logic enterRun     = state_d == ST_RUN && state_q != ST_RUN;

  // Next state; a calibrate strobe outside idle is ignored, a power-down strobe stays armed until sleep is entered from idle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (sleepGo) begin
          state_d = ST_SLEEP;
        end else if (synthOnReq) begin
          state_d = (autoTunePolicy == `STP_POLICY_ON_START) ? ST_CAL : ST_RUN;
        end else if (calibrateStrobe && manualPolicy) begin
          state_d = ST_CAL;
        end
      end
      ST_CAL: begin
        if (calDone) begin
          state_d = synthOnReq ? ST_RUN : ST_IDLE;
        end
      end
      ST_RUN: begin
        if (!synthOnReq) begin
          state_d = (autoTunePolicy == `STP_POLICY_ON_STOP) ? ST_CAL : ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (csLow) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Status flops follow the next state, so they always match the state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      synthRun_q <= 1'b0;
      calBusy_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      synthRun_q <= state_d == ST_RUN;
      calBusy_q  <= state_d == ST_CAL;
    end
  end

  // Calibration timer
  always_ff @(posedge clock) begin
    if (sys_rst || state_q != ST_CAL) begin
      calCnt_q <= 32'h0000_0000;
    end else begin
      calCnt_q <= calCnt_q + 32'h0000_0001;
    end
  end

  // Words are only applied at a start, so idle edits cannot disturb a running loop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      synthWord_q <= 27'h000_0000;
      ifWord_q    <= '0;
    end else if (enterCal || enterRun) begin
      synthWord_q <= carrierWord;
      ifWord_q    <= intermediateTuningWord;
    end
  end

  // Trim result, untouched in sleep so it is valid after wake
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trim_q <= `STP_TRIM_UNLOCKED;
    end else if (calDone) begin
      trim_q <= (locked && trimCode != `STP_TRIM_UNLOCKED) ? trimCode : `STP_TRIM_UNLOCKED;
    end
  end

  // Status and lock pin; a rising pin edge marks lock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trimStat_q <= `STP_TRIM_UNLOCKED;
      pin_q      <= 1'b0;
    end else begin
      trimStat_q <= locked ? trim_q : `STP_TRIM_UNLOCKED;
      pin_q      <= (outputPinSelect == `STP_PIN_SEL_LOCK) && locked;
    end
  end

  // Power-down arm, core supply and oscillator start
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pdArmed_q <= 1'b0;
      coreOn_q  <= 1'b1;
    end else begin
      if (powerDownStrobe) begin
        pdArmed_q <= 1'b1;
      end else if (state_d == ST_SLEEP) begin
        pdArmed_q <= 1'b0;
      end
      coreOn_q <= state_d != ST_SLEEP;
    end
  end

  // Serial output held high until the oscillator settles
  always_ff @(posedge clock) begin
    if (sys_rst || !coreOn_q) begin
      xoscCnt_q  <= 32'h0000_0000;
      chipRdyN_q <= 1'b1;
    end else if (xoscCnt_q == 32'(XOSC_CYC - 1)) begin
      chipRdyN_q <= 1'b0;
    end else begin
      xoscCnt_q <= xoscCnt_q + 32'h0000_0001;
    end
  end

  // Sticky flag: serial clock rose before the device was ready
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      earlyClk_q <= 1'b0;
    end else if (csLow && sclkRise && chipRdyN_q) begin
      earlyClk_q <= 1'b1;
    end
  end

  // Table writes; entries above 0 only in burst access
  assign tab.wrEn       = tableWrEn && (tableWrIdx == 3'h0 || tableBurst);
  assign tab.wrIdx      = tableWrIdx;
  assign tab.wrData     = tableWrData;
  assign tab.sleepClear = state_q != ST_SLEEP && state_d == ST_SLEEP;

  // Power index target per modulation
  logic [2:0] pwrIdx_q;
  logic       paEn_q;
  wire logic [2:0] rampTarget = !txActive ? 3'h0 :
                                askMode   ? (txBit ? rampTopIndex : 3'h0) :
                                rampTopIndex;
  wire logic [2:0] ookIdx     = txActive ? {2'b00, txBit} : 3'h0;
  wire logic [2:0] stepIdx    = (pwrIdx_q < rampTarget) ? pwrIdx_q + 3'h1 :
                                (pwrIdx_q > rampTarget) ? pwrIdx_q - 3'h1 : pwrIdx_q;

  // Ramp one entry per shaping tick, saturating at top and zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwrIdx_q <= 3'h0;
    end else if (ookMode) begin
      pwrIdx_q <= ookIdx;
    end else if (rampTopIndex == 3'h0) begin
      pwrIdx_q <= 3'h0;
    end else if (shapeTick) begin
      pwrIdx_q <= stepIdx;
    end
  end

  assign tab.rdIdx = pwrIdx_q;

  // Amplifier stays on through ramp-down
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      paEn_q <= 1'b0;
    end else begin
      paEn_q <= txActive || pwrIdx_q != 3'h0;
    end
  end

  assign synthWord        = synthWord_q;
  assign ifWord           = ifWord_q;
  assign synthRunning     = synthRun_q;
  assign calBusy          = calBusy_q;
  assign synthTrimStatus  = trimStat_q;
  assign generalOutputPin = pin_q;
  assign coreOn           = coreOn_q;
  assign serialOut        = chipRdyN_q;
  assign earlyClkError    = earlyClk_q;
  assign paLevel          = tab.rdData;
  assign paEnable         = paEn_q;

  lock_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(generalOutputPin) |-> outputPinSelect == `STP_PIN_SEL_LOCK || $past(outputPinSelect) == `STP_PIN_SEL_LOCK)
    else $error("lock pin rose without lock select");
  trim_unlock_a: assert property (@(posedge clock) disable iff (sys_rst)
    !lockSync_q[1] |=> synthTrimStatus == `STP_TRIM_UNLOCKED)
    else $error("trim status not 0x3f while unlocked");
  manual_cal_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_IDLE && calibrateStrobe && manualPolicy && !synthOnReq && !sleepGo |=> calBusy)
    else $error("calibrate strobe in idle did not start calibration");
  auto_start_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_IDLE && synthOnReq && !sleepGo && autoTunePolicy == `STP_POLICY_ON_START |=> calBusy)
    else $error("synth start did not calibrate");
  cal_length_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(calBusy) |-> calBusy [*8])
    else $error("calibration ended too soon");
  base_carrier_word_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_RUN && $past(state_q) == ST_RUN |-> $stable(synthWord))
    else $error("synth word changed while running");
  sleep_core_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_IDLE && sleepGo |=> !coreOn ##0 state_q == ST_SLEEP)
    else $error("core not powered down on sleep");
  no_ramp_a: assert property (@(posedge clock) disable iff (sys_rst)
    rampTopIndex == 3'h0 && !ookMode |=> pwrIdx_q == 3'h0)
    else $error("index moved with top index zero");
  ook_idx_a: assert property (@(posedge clock) disable iff (sys_rst)
    ookMode && txActive |=> pwrIdx_q == {2'b00, $past(txBit)})
    else $error("on-off keying index wrong");

endmodule

// >>> verification/stp_host_model.sv
`timescale 1ns/10ps
// Host end of the serial port: selects the device, then clocks a short frame
module stp_host_model (
  input  wire logic selReq,
  input  wire logic eager,
  input  wire logic serialOut,
  output logic      chipSelectN,
  output logic      serialClk
);
  // Deselected and clock low until the first frame
  initial begin
    chipSelectN = 1'b1;
    serialClk   = 1'b0;
  end
  // Clock waits for ready unless eager, which models a faulty host
  always begin
    wait (selReq);
    #3 chipSelectN = 1'b0;
    wait (!serialOut || eager);
    repeat (4) begin
      #40 serialClk = 1'b1;
      #40 serialClk = 1'b0;
    end
    wait (!selReq);
    #3 chipSelectN = 1'b1;
  end
endmodule

// >>> verification/stp_synth_ctrl_tb.sv
`timescale 1ns/10ps
module stp_synth_ctrl_tb;
  import stp_pkg::*;
  typedef struct packed {
    logic [23:0] b;
    logic [7:0]  s;
    logic [7:0]  m;
    logic [1:0]  e;
    logic [4:0]  i;
    logic [26:0] w;
  } stp_frow_s;
  logic        clock = 1'b0, sysRst = 1'b1, selReq = 1'b0, hostEager = 1'b0;
  logic [7:0]  baseWordHi, baseWordMid, baseWordLo, carrierSlotNumber, spacingMantissa, tableWrData, paLevel;
  logic [4:0]  intermediateTuningWord, ifWord;
  logic [5:0]  trimCode, outputPinSelect, synthTrimStatus;
  logic [2:0]  tableWrIdx, rampTopIndex;
  logic [1:0]  spacingExponent, autoTunePolicy;
  logic [26:0] synthWord;
  logic        calibrateStrobe, powerDownStrobe, synthOnReq, pllLockRaw, chipSelectN, serialClk, tableWrEn;
  logic        tableBurst, txActive, askMode, ookMode, txBit, shapeTick, synthRunning, calBusy;
  logic        generalOutputPin, coreOn, serialOut, earlyClkError, paEnable;
  int          fails = 0, nChecks = 0;
  // Inputs beside the carrier word they must give
  stp_frow_s   rows [4] = '{
    '{24'h10b071, 8'h00, 8'hf8, 2'h2, 5'h06, 27'h042c1c4},
    '{24'h21623b, 8'h01, 8'h00, 2'h0, 5'h1f, 27'h08589ec},
    '{24'h000000, 8'hff, 8'hff, 2'h3, 5'h00, 27'h00fe808},
    '{24'hffffff, 8'h07, 8'h3a, 2'h1, 5'h0c, 27'h4001128}};

  always #5 clock = ~clock;

  // Short calibration and start-up counts keep the run brief
  stp_synth_ctrl #(.CAL_CYCLES(10), .XOSC_CYC(8)) stp_synth_ctrl_inst (
    .clock, .sys_rst(sysRst), .baseWordHi, .baseWordMid, .baseWordLo, .carrierSlotNumber, .spacingMantissa,
    .spacingExponent, .intermediateTuningWord, .autoTunePolicy, .calibrateStrobe, .powerDownStrobe, .synthOnReq,
    .pllLockRaw, .trimCode, .outputPinSelect, .chipSelectN, .serialClk, .tableWrEn, .tableBurst, .tableWrIdx,
    .tableWrData, .rampTopIndex, .txActive, .askMode, .ookMode, .txBit, .shapeTick, .synthWord, .ifWord,
    .synthRunning, .calBusy, .synthTrimStatus, .generalOutputPin, .coreOn, .serialOut, .earlyClkError, .paLevel,
    .paEnable);
  stp_host_model stp_host_model_inst (.selReq, .eager(hostEager), .serialOut, .chipSelectN, .serialClk);

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nChecks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic waitSig(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(negedge clock);
      n++;
    end
  endtask
  // Calibration must stand exactly its programmed length
  task automatic waitCal();
    int n;
    waitSig(calBusy, 1'b1);
    n = 0;
    while (calBusy === 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    chk("calCycles", 10, n);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d, input logic bst);
    tableWrIdx  = i;
    tableWrData = d;
    tableBurst  = bst;
    pulse(tableWrEn);
  endtask
  task automatic tick();
    pulse(shapeTick);
    w(3);
  endtask
  function automatic logic [7:0] lv(input int i);
    return (i < 4) ? 8'(8'h11 * (i + 1)) : 8'hc6;
  endfunction
  task endOfTest();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected few microseconds
  initial begin
    #300000;
    fails++;
    endOfTest();
  end

  initial begin
    {baseWordHi, baseWordMid, baseWordLo, carrierSlotNumber, spacingMantissa, spacingExponent} = '0;
    {intermediateTuningWord, autoTunePolicy, calibrateStrobe, powerDownStrobe, synthOnReq, pllLockRaw} = '0;
    {trimCode, outputPinSelect, tableWrEn, tableBurst, tableWrIdx, tableWrData, rampTopIndex} = '0;
    {txActive, askMode, ookMode, txBit, shapeTick} = '0;
    w(2);
    sysRst = 1'b0;
    chk("trimRst", 6'h3f, synthTrimStatus);
    chk("paRst", 8'hc6, paLevel);
    chk("synthRst", 0, synthWord);
    waitSig(serialOut, 1'b0);
    chk("readyRst", 0, {coreOn, serialOut} ^ 2'b10);
    $display("TEST reset done");
    // Frequency fields change only while idle, then a calibration latches them
    foreach (rows[r]) begin
      {baseWordHi, baseWordMid, baseWordLo} = rows[r].b;
      {carrierSlotNumber, spacingMantissa, spacingExponent} = {rows[r].s, rows[r].m, rows[r].e};
      intermediateTuningWord = rows[r].i;
      waitCal_start();
      chk("synthWord", rows[r].w, synthWord);
      chk("ifWord", rows[r].i, ifWord);
    end
    baseWordHi = 8'h55;
    w(3);
    chk("synthHeld", rows[3].w, synthWord);
    $display("TEST frequency done");
    pllLockRaw      = 1'b1;
    outputPinSelect = 6'h0a;
    trimCode        = 6'h15;
    waitCal_start();
    w(2);
    chk("lockPin", 1, generalOutputPin);
    chk("trimLock", 6'h15, synthTrimStatus);
    outputPinSelect = 6'h09;
    w(3);
    chk("pinOther", 0, generalOutputPin);
    pllLockRaw = 1'b0;
    w(5);
    chk("trimLoss", 6'h3f, synthTrimStatus);
    pllLockRaw = 1'b1;
    w(5);
    $display("TEST lock done");
    autoTunePolicy = 2'h1;
    pulse(calibrateStrobe);
    w(4);
    chk("strobeRefused", 0, calBusy);
    synthOnReq = 1'b1;
    waitCal();
    chk("runAfterCal", 1, synthRunning);
    synthOnReq = 1'b0;
    w(3);
    autoTunePolicy = 2'h2;
    synthOnReq     = 1'b1;
    w(3);
    chk("runNoCal", 2'b10, {synthRunning, calBusy});
    synthOnReq = 1'b0;
    waitCal();
    autoTunePolicy = 2'h0;
    $display("TEST policy done");
    for (int i = 0; i < 4; i++)
      wr(3'(i), lv(i), 1'b1);
    wr(3'h1, 8'h77, 1'b0);
    for (int m = 0; m < 2; m++) begin
      askMode      = 1'(m);
      rampTopIndex = 3'h4;
      txActive     = 1'b1;
      txBit        = 1'b1;
      w(3);
      chk("rampStart", lv(0), paLevel);
      for (int i = 1; i < 6; i++) begin
        tick();
        chk("rampUp", lv(i > 4 ? 4 : i), paLevel);
      end
      if (m == 1)
        txBit = 1'b0;
      else
        txActive = 1'b0;
      for (int i = 3; i >= 0; i--) begin
        tick();
        chk("rampDown", lv(i), paLevel);
      end
      txActive = 1'b0;
      w(2);
      chk("paOff", 0, paEnable);
    end
    rampTopIndex = 3'h0;
    txActive     = 1'b1;
    tick();
    chk("noRamp", lv(0), paLevel);
    ookMode = 1'b1;
    txBit   = 1'b1;
    w(3);
    chk("ookOne", lv(1), paLevel);
    txBit = 1'b0;
    w(3);
    chk("ookZero", lv(0), paLevel);
    txActive = 1'b0;
    $display("TEST table done");
    pulse(powerDownStrobe);
    w(4);
    chk("sleepCore", 0, coreOn);
    selReq = 1'b1;
    waitSig(serialOut, 1'b0);
    chk("wakeCore", 2'b10, {coreOn, serialOut});
    w(60);
    selReq = 1'b0;
    chk("earlyClk", 0, earlyClkError);
    chk("trimKept", 6'h15, synthTrimStatus);
    txActive = 1'b1;
    txBit    = 1'b1;
    w(3);
    chk("lostEntry", 8'h00, paLevel);
    txBit = 1'b0;
    w(3);
    chk("keptEntry", lv(0), paLevel);
    $display("TEST sleep done");
    // A host that clocks before ready must raise the sticky flag
    txActive  = 1'b0;
    hostEager = 1'b1;
    pulse(powerDownStrobe);
    w(4);
    chk("sleepAgain", 0, coreOn);
    selReq = 1'b1;
    w(40);
    selReq = 1'b0;
    chk("earlyClkSet", 1, earlyClkError);
    hostEager = 1'b0;
    w(5);
    $display("TEST early clock done");
    // Reset in mid-run clears the sticky flag and restores defaults
    sysRst = 1'b1;
    w(2);
    sysRst = 1'b0;
    chk("earlyRst", 0, earlyClkError);
    chk("trimRst2", 6'h3f, synthTrimStatus);
    chk("paRst2", 8'hc6, paLevel);
    chk("synthRst2", 0, synthWord);
    waitSig(serialOut, 1'b0);
    chk("readyRst2", 2'b10, {coreOn, serialOut});
    $display("TEST reset again done");
    endOfTest();
  end

  // Manual calibration request issued from idle
  task automatic waitCal_start();
    pulse(calibrateStrobe);
    waitCal();
  endtask
endmodule
